// File: src/lookup_hash.sv
package lookup_pkg;
  // ------------------------------------------------------------
  // Table geometry
  // ------------------------------------------------------------
  localparam int MAC_W          = 48;
  localparam int FID_W          = 7;
  localparam int IDX_W          = 10;
  localparam int BUCKETS        = 1024;
  localparam int WAYS           = 4;
  localparam int WAY_W          = 2;
  localparam int MAIN_ENTRIES   = BUCKETS * WAYS;
  localparam int STATIC_ENTRIES = 16;
  localparam int STATIC_W       = 4;
  localparam int RSVD_ENTRIES   = 8;
  localparam int PORTS          = 6;
  localparam int PORT_W         = 3;

  // ------------------------------------------------------------
  // Hash selection and coding
  // ------------------------------------------------------------
  localparam logic [1:0]       HASH_DIRECT  = 2'h0;
  localparam logic [1:0]       HASH_CRC     = 2'h1;
  localparam logic [1:0]       HASH_XOR     = 2'h2;
  localparam logic [1:0]       HASH_DEFAULT = HASH_CRC;
  localparam int               CRC_W        = 16;
  localparam logic [CRC_W-1:0] CRC_POLY     = 16'h1021;
  localparam logic [CRC_W-1:0] CRC_INIT     = 16'h0000;
  localparam logic [FID_W-1:0] FID_DEFAULT  = 7'h00;

  // ------------------------------------------------------------
  // Shared frame buffer
  // ------------------------------------------------------------
  localparam int            LEN_W     = 19;
  localparam logic [LEN_W:0] BUF_BYTES = 20'h40000;

  // ------------------------------------------------------------
  // Reserved multicast groups
  // ------------------------------------------------------------
  localparam logic [39:0]           RSVD_PREFIX  = 40'h0180C20000;
  localparam logic [PORTS*8-1:0]    RSVD_PORTS   =
    {6'h3F, 6'h20, 6'h3F, 6'h3F, 6'h3F, 6'h20, 6'h00, 6'h20};
  localparam logic [PORTS-1:0]      ALL_PORTS    = 6'h3F;

  typedef enum logic [2:0] {
    SRC_FLOOD, SRC_MAIN_DYN, SRC_MAIN_STATIC, SRC_RSVD, SRC_STATIC_TBL, SRC_DROP
  } result_src_e;

  // Low address byte to reserved group; bit 3 marks a member address
  function automatic logic [3:0] rsvd_group(input logic [7:0] low);
    logic [3:0] g;
    g = 4'h0;
    if (low == 8'h00)                      g = 4'h8;
    else if (low == 8'h01)                 g = 4'h9;
    else if (low == 8'h03)                 g = 4'hA;
    else if (low == 8'h10)                 g = 4'hB;
    else if (low == 8'h20)                 g = 4'hC;
    else if (low == 8'h21)                 g = 4'hD;
    else if (low <= 8'h0F)                 g = 4'hE;
    else if (low <= 8'h2F)                 g = 4'hF;
    return g;
  endfunction : rsvd_group
endpackage : lookup_pkg

`timescale 1ns/1ps
`default_nettype none
module bucket_index_hash (
  // Key
  input  wire logic [lookup_pkg::MAC_W-1:0] mac_i,
  input  wire logic [lookup_pkg::FID_W-1:0] fid_i,
  input  wire logic [1:0]                   mode_i,
  // Bucket
  output logic      [lookup_pkg::IDX_W-1:0] index_o
);
  logic [lookup_pkg::CRC_W-1:0] crc;
  logic [lookup_pkg::CRC_W-1:0] fold;
  logic [lookup_pkg::IDX_W-1:0] fid_ext;
  logic [lookup_pkg::MAC_W+lookup_pkg::FID_W-1:0] key;
  logic fb;

  always_comb begin
    key = {mac_i, fid_i};
    crc = lookup_pkg::CRC_INIT;
    fb  = 1'b0;
    for (int i = lookup_pkg::MAC_W + lookup_pkg::FID_W - 1; i >= 0; i--) begin
      fb  = crc[lookup_pkg::CRC_W-1] ^ key[i];
      crc = {crc[lookup_pkg::CRC_W-2:0], 1'b0} ^ (fb ? lookup_pkg::CRC_POLY : '0);
    end
    fold    = mac_i[47:32] ^ mac_i[31:16] ^ mac_i[15:0];
    fid_ext = {3'h0, fid_i};
    // Sums are cut to ten bits, so the bucket wraps inside the table
    case (mode_i)
      lookup_pkg::HASH_CRC: index_o = crc[9:0] + fid_ext;
      lookup_pkg::HASH_XOR: index_o = fold[9:0] + fid_ext;
      default:              index_o = mac_i[9:0] + fid_ext;
    endcase
  end
endmodule : bucket_index_hash
`default_nettype wire

// File: src/mac_address_lookup_index.sv
`timescale 1ns/1ps
`default_nettype none
module mac_address_lookup_index #(
  parameter int PORTS = lookup_pkg::PORTS
) (
  // Clock and reset
  input  wire logic                          clock_i,
  input  wire logic                          sys_rst_i,
  // Configuration
  input  wire logic                          vlan_en_i,
  input  wire logic [1:0]                    hash_mode_i,
  input  wire logic                          rsvd_en_i,
  input  wire logic [PORTS-1:0]              host_port_i,
  // Lookup request from receive ports
  input  wire logic                          lkp_req_i,
  input  wire logic                          lkp_frame_done_i,
  input  wire logic                          lkp_frame_err_i,
  input  wire logic [lookup_pkg::MAC_W-1:0]  lkp_dst_mac_i,
  input  wire logic [lookup_pkg::FID_W-1:0]  lkp_fid_i,
  input  wire logic [lookup_pkg::PORT_W-1:0] lkp_src_port_i,
  input  wire logic [lookup_pkg::LEN_W-1:0]  lkp_len_i,
  output logic                               lkp_room_o,
  // Forwarding result
  output logic                               fwd_valid_o,
  output logic [PORTS-1:0]                   fwd_ports_o,
  output lookup_pkg::result_src_e            fwd_source_o,
  // Buffer release from egress
  input  wire logic                          buf_release_i,
  input  wire logic [lookup_pkg::LEN_W-1:0]  buf_release_len_i,
  // Source learning
  input  wire logic                          learn_req_i,
  input  wire logic [lookup_pkg::MAC_W-1:0]  learn_mac_i,
  input  wire logic [lookup_pkg::FID_W-1:0]  learn_fid_i,
  input  wire logic [lookup_pkg::PORT_W-1:0] learn_port_i,
  // Management writes
  input  wire logic                          mgmt_wr_i,
  input  wire logic                          mgmt_to_static_tbl_i,
  input  wire logic [lookup_pkg::STATIC_W-1:0] mgmt_sel_i,
  input  wire logic                          mgmt_entry_valid_i,
  input  wire logic [lookup_pkg::MAC_W-1:0]  mgmt_mac_i,
  input  wire logic [lookup_pkg::FID_W-1:0]  mgmt_fid_i,
  input  wire logic [PORTS-1:0]              mgmt_ports_i
);
  import lookup_pkg::*;

  function automatic logic [PORTS-1:0] port_mask(input logic [PORT_W-1:0] p);
    port_mask = '0;
    port_mask[p] = 1'b1;
  endfunction : port_mask

  // ------------------------------------------------------------
  // Tables
  // ------------------------------------------------------------
  logic [MAC_W-1:0] main_mac    [BUCKETS][WAYS];
  logic [FID_W-1:0] main_fid    [BUCKETS][WAYS];
  logic [PORTS-1:0] main_ports  [BUCKETS][WAYS];
  logic [WAYS-1:0]  main_valid  [BUCKETS];
  logic [WAYS-1:0]  main_static [BUCKETS];
  logic [MAC_W-1:0] st_mac      [STATIC_ENTRIES];
  logic [FID_W-1:0] st_fid      [STATIC_ENTRIES];
  logic [PORTS-1:0] st_ports    [STATIC_ENTRIES];
  logic [STATIC_ENTRIES-1:0] st_valid;

  // ------------------------------------------------------------
  // Hashing
  // ------------------------------------------------------------
  logic [FID_W-1:0] lkp_fid_eff;
  logic [FID_W-1:0] wr_fid_eff;
  logic [IDX_W-1:0] lkp_idx;
  logic [IDX_W-1:0] wr_idx;
  logic [MAC_W-1:0] wr_mac;

  assign lkp_fid_eff = vlan_en_i ? lkp_fid_i : FID_DEFAULT;
  assign wr_mac      = mgmt_wr_i ? mgmt_mac_i : learn_mac_i;
  assign wr_fid_eff  = vlan_en_i ? (mgmt_wr_i ? mgmt_fid_i : learn_fid_i) : FID_DEFAULT;

  bucket_index_hash u_lkp_hash (
    .mac_i   (lkp_dst_mac_i),
    .fid_i   (lkp_fid_eff),
    .mode_i  (hash_mode_i),
    .index_o (lkp_idx)
  );
  bucket_index_hash u_wr_hash (
    .mac_i   (wr_mac),
    .fid_i   (wr_fid_eff),
    .mode_i  (hash_mode_i),
    .index_o (wr_idx)
  );

  // ------------------------------------------------------------
  // Learning and management writes
  // ------------------------------------------------------------
  logic             learn_do;
  logic [WAY_W-1:0] learn_way;
  logic [WAY_W-1:0] rr;
  logic [WAY_W-1:0] next_rr;
  logic             found;
  logic             found_free;

  always_comb begin
    learn_do   = 1'b0;
    learn_way  = rr;
    found      = 1'b0;
    found_free = 1'b0;
    for (int w = 0; w < WAYS; w++) begin
      if (!found && main_valid[wr_idx][w] && main_mac[wr_idx][w] == learn_mac_i &&
          main_fid[wr_idx][w] == wr_fid_eff) begin
        found     = 1'b1;
        learn_way = WAY_W'(w);
      end
    end
    for (int w = WAYS - 1; w >= 0; w--) begin
      if (!found && !main_valid[wr_idx][w]) begin
        found_free = 1'b1;
        learn_way  = WAY_W'(w);
      end
    end
    // Existing static entries are never moved or evicted by learning
    if (found)
      learn_do = !main_static[wr_idx][learn_way];
    else if (found_free)
      learn_do = 1'b1;
    else
      learn_do = !main_static[wr_idx][rr];
    learn_do = learn_do && learn_req_i && !mgmt_wr_i;
    next_rr  = (learn_do && !found && !found_free) ? rr + 1'b1 : rr;
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rr       <= '0;
      st_valid <= '0;
      for (int b = 0; b < BUCKETS; b++) begin
        main_valid[b]  <= '0;
        main_static[b] <= '0;
      end
    end else begin
      rr <= next_rr;
      if (mgmt_wr_i && mgmt_to_static_tbl_i) begin
        st_valid[mgmt_sel_i] <= mgmt_entry_valid_i;
        st_mac[mgmt_sel_i]   <= mgmt_mac_i;
        st_fid[mgmt_sel_i]   <= wr_fid_eff;
        st_ports[mgmt_sel_i] <= mgmt_ports_i;
      end else if (mgmt_wr_i) begin
        main_valid[wr_idx][mgmt_sel_i[WAY_W-1:0]]  <= mgmt_entry_valid_i;
        main_static[wr_idx][mgmt_sel_i[WAY_W-1:0]] <= 1'b1;
        main_mac[wr_idx][mgmt_sel_i[WAY_W-1:0]]    <= mgmt_mac_i;
        main_fid[wr_idx][mgmt_sel_i[WAY_W-1:0]]    <= wr_fid_eff;
        main_ports[wr_idx][mgmt_sel_i[WAY_W-1:0]]  <= mgmt_ports_i;
      end else if (learn_do) begin
        main_valid[wr_idx][learn_way]  <= 1'b1;
        main_static[wr_idx][learn_way] <= 1'b0;
        main_mac[wr_idx][learn_way]    <= learn_mac_i;
        main_fid[wr_idx][learn_way]    <= wr_fid_eff;
        main_ports[wr_idx][learn_way]  <= port_mask(learn_port_i);
      end
    end
  end

  // ------------------------------------------------------------
  // Shared buffer accounting
  // ------------------------------------------------------------
  logic [LEN_W-1:0] buf_used;
  logic [LEN_W-1:0] next_buf_used;
  logic             take;
  logic             admit;

  assign lkp_room_o = ({1'b0, buf_used} + {1'b0, lkp_len_i}) <= BUF_BYTES;
  assign take       = lkp_req_i && lkp_frame_done_i;
  assign admit      = take && !lkp_frame_err_i && lkp_room_o;

  always_comb begin
    next_buf_used = buf_used;
    if (admit)
      next_buf_used = next_buf_used + lkp_len_i;
    if (buf_release_i)
      next_buf_used = next_buf_used - buf_release_len_i;
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i)
      buf_used <= '0;
    else
      buf_used <= next_buf_used;
  end

  // ------------------------------------------------------------
  // Lookup pipeline
  // ------------------------------------------------------------
  logic              s1_valid;
  logic              s1_ok;
  logic [MAC_W-1:0]  s1_mac;
  logic [FID_W-1:0]  s1_fid;
  logic [PORT_W-1:0] s1_src;
  logic [IDX_W-1:0]  s1_idx;
  logic [1:0]        s1_mode;
  logic [PORTS-1:0]  res_ports;
  result_src_e       res_src;
  logic              st_hit;
  logic [3:0]        grp;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      s1_valid <= 1'b0;
      s1_ok    <= 1'b0;
      s1_mac   <= '0;
      s1_fid   <= '0;
      s1_src   <= '0;
      s1_idx   <= '0;
      s1_mode  <= HASH_DEFAULT;
    end else begin
      s1_valid <= take;
      s1_ok    <= admit;
      s1_mac   <= lkp_dst_mac_i;
      s1_fid   <= lkp_fid_eff;
      s1_src   <= lkp_src_port_i;
      s1_idx   <= lkp_idx;
      s1_mode  <= hash_mode_i;
    end
  end

  // Later checks override earlier ones, so the order sets the priority
  always_comb begin
    res_ports = ALL_PORTS[PORTS-1:0];
    res_src   = SRC_FLOOD;
    st_hit    = 1'b0;
    grp       = rsvd_group(s1_mac[7:0]);
    for (int w = 0; w < WAYS; w++) begin
      if (main_valid[s1_idx][w] && !main_static[s1_idx][w] &&
          main_mac[s1_idx][w] == s1_mac && main_fid[s1_idx][w] == s1_fid) begin
        res_ports = main_ports[s1_idx][w];
        res_src   = SRC_MAIN_DYN;
      end
    end
    for (int w = 0; w < WAYS; w++) begin
      if (main_valid[s1_idx][w] && main_static[s1_idx][w] &&
          main_mac[s1_idx][w] == s1_mac && main_fid[s1_idx][w] == s1_fid) begin
        res_ports = main_ports[s1_idx][w];
        res_src   = SRC_MAIN_STATIC;
      end
    end
    if (rsvd_en_i && s1_mac[47:8] == RSVD_PREFIX && grp[3]) begin
      res_ports = RSVD_PORTS[grp[2:0]*PORTS +: PORTS];
      res_src   = SRC_RSVD;
    end
    for (int s = STATIC_ENTRIES - 1; s >= 0; s--) begin
      if (st_valid[s] && st_mac[s] == s1_mac && st_fid[s] == s1_fid) begin
        res_ports = st_ports[s];
        res_src   = SRC_STATIC_TBL;
        st_hit    = 1'b1;
      end
    end
    // Never send a frame back out of its arrival port
    res_ports = res_ports & ~port_mask(s1_src);
    if (!s1_ok) begin
      res_ports = '0;
      res_src   = SRC_DROP;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      fwd_valid_o  <= 1'b0;
      fwd_ports_o  <= '0;
      fwd_source_o <= SRC_DROP;
    end else begin
      fwd_valid_o  <= s1_valid;
      fwd_ports_o  <= res_ports;
      fwd_source_o <= res_src;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  logic [15:0] fold_chk;
  assign fold_chk = s1_mac[47:32] ^ s1_mac[31:16] ^ s1_mac[15:0];

  sequence req_taken_s;
    lkp_req_i && lkp_frame_done_i;
  endsequence
  sequence result_out_s;
    ##2 fwd_valid_o;
  endsequence

  chk_result_latency: assert property (req_taken_s |-> result_out_s)
    else $error("lookup result not produced two cycles after request");
  chk_store_fwd: assert property (s1_valid |-> $past(lkp_frame_done_i))
    else $error("lookup started before frame was complete");
  chk_no_local_port: assert property (fwd_valid_o |-> (fwd_ports_o & port_mask($past(s1_src))) == '0)
    else $error("frame forwarded to its arrival port");
  chk_flood_miss: assert property (fwd_valid_o && fwd_source_o == SRC_FLOOD |-> fwd_ports_o == (ALL_PORTS & ~port_mask($past(s1_src))))
    else $error("unknown destination not flooded");
  chk_vlan_off_fid: assert property (req_taken_s and !vlan_en_i |=> s1_fid == FID_DEFAULT)
    else $error("filter group not zero with VLAN disabled");
  chk_xor_index: assert property (s1_valid && s1_mode == HASH_XOR |-> s1_idx == IDX_W'(fold_chk[9:0] + {3'h0, s1_fid}))
    else $error("XOR bucket index wrong");
  chk_direct_index: assert property (s1_valid && (s1_mode == HASH_DIRECT || s1_mode == 2'h3) |-> s1_idx == IDX_W'(s1_mac[9:0] + {3'h0, s1_fid}))
    else $error("direct bucket index wrong");
  chk_static_wins: assert property (s1_ok && st_hit |=> fwd_source_o == SRC_STATIC_TBL)
    else $error("static table hit lost priority");
  chk_buffer_limit: assert property ({1'b0, buf_used} <= BUF_BYTES)
    else $error("shared buffer overcommitted");
  chk_learn_dynamic: assert property (learn_do |=> !main_static[$past(wr_idx)][$past(learn_way)])
    else $error("learning created a static entry");
endmodule : mac_address_lookup_index
`default_nettype wire

// File: bench/rx_port_model.sv
`timescale 1ns/1ps
`default_nettype none
module rx_port_model (
  // Clock
  input  wire logic        clock_i,
  // Requests and learning
  output logic             req_o,
  output logic             done_o,
  output logic             err_o,
  output logic             learn_o,
  output logic [47:0]      mac_o,
  output logic [6:0]       fid_o,
  output logic [2:0]       src_o,
  output logic [18:0]      len_o,
  // Egress release
  output logic             rel_o,
  output logic [18:0]      rel_len_o,
  // Results
  input  wire logic        fwd_valid_i,
  input  wire logic [5:0]  fwd_ports_i,
  input  wire logic [2:0]  fwd_source_i
);
  // ------------------------------------------------------------
  // Receive side and forwarding sink
  // ------------------------------------------------------------
  int unsigned cyc = 0;
  int unsigned take_q[$];
  int unsigned rc_q[$];
  logic [5:0]  rp_q[$];
  logic [2:0]  rs_q[$];

  initial begin
    {req_o, done_o, err_o, learn_o, rel_o} = 5'h00;
    {mac_o, fid_o, src_o, len_o, rel_len_o} = '0;
  end

  always @(posedge clock_i) cyc <= cyc + 1;

  always @(negedge clock_i) begin
    if (fwd_valid_i === 1'b1) begin
      rp_q.push_back(fwd_ports_i);
      rs_q.push_back(fwd_source_i);
      rc_q.push_back(cyc);
    end
  end

  // Request stays up until idle; back-to-back sends never toggle it in one step
  task automatic send(input logic [47:0] mac, input logic [6:0] filter_group_id, input logic [2:0] src,
                      input logic [18:0] len, input logic err, input logic done);
    @(negedge clock_i);
    {req_o, done_o, err_o} = {1'b1, done, err};
    {mac_o, fid_o, src_o, len_o} = {mac, filter_group_id, src, len};
    if (done) take_q.push_back(cyc + 1);
  endtask : send

  task automatic idle;
    @(negedge clock_i);
    {req_o, learn_o, rel_o} = 3'h0;
    // Released address lines show no stale value
    mac_o = ~mac_o;
  endtask : idle

  task automatic learn(input logic [47:0] mac, input logic [6:0] filter_group_id, input logic [2:0] port);
    @(negedge clock_i);
    learn_o = 1'b1;
    {mac_o, fid_o, src_o} = {mac, filter_group_id, port};
    idle();
  endtask : learn

  task automatic release_buf(input logic [18:0] len);
    @(negedge clock_i);
    {rel_o, rel_len_o} = {1'b1, len};
    idle();
  endtask : release_buf
endmodule : rx_port_model
`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ------------------------------------------------------------
  // Wiring
  // ------------------------------------------------------------
  logic clock = 1'b0, sys_rst = 1'b1, vlan_en = 1'b0, rsvd_en = 1'b0;
  logic [1:0] hash_mode = lookup_pkg::HASH_DEFAULT;
  logic req, done, err, learn, rel, room, fwd_valid, m_wr = 1'b0, m_tbl = 1'b0;
  logic [47:0] mac, m_mac = '0;
  logic [6:0] filter_group_id;
  logic [2:0] src;
  logic [18:0] len, rel_len;
  logic [5:0] fwd_ports, m_ports = '0;
  logic [3:0] m_sel = '0;
  lookup_pkg::result_src_e fwd_source;
  int n_mismatch = 0, checks = 0, cycles = 0;

  initial forever #5 clock = ~clock;

  mac_address_lookup_index #(.PORTS(6)) DUT (.clock_i(clock), .sys_rst_i(sys_rst),
    .vlan_en_i(vlan_en), .hash_mode_i(hash_mode), .rsvd_en_i(rsvd_en),
    .host_port_i(6'h20),
    .lkp_req_i(req), .lkp_frame_done_i(done), .lkp_frame_err_i(err), .lkp_dst_mac_i(mac),
    .lkp_fid_i(filter_group_id), .lkp_src_port_i(src), .lkp_len_i(len), .lkp_room_o(room),
    .fwd_valid_o(fwd_valid), .fwd_ports_o(fwd_ports), .fwd_source_o(fwd_source),
    .buf_release_i(rel), .buf_release_len_i(rel_len), .learn_req_i(learn),
    .learn_mac_i(mac), .learn_fid_i(filter_group_id), .learn_port_i(src), .mgmt_wr_i(m_wr),
    .mgmt_to_static_tbl_i(m_tbl), .mgmt_sel_i(m_sel), .mgmt_entry_valid_i(1'b1),
    .mgmt_mac_i(m_mac), .mgmt_fid_i(7'h00), .mgmt_ports_i(m_ports));

  rx_port_model rx (.clock_i(clock), .req_o(req), .done_o(done), .err_o(err),
    .learn_o(learn), .mac_o(mac), .fid_o(filter_group_id), .src_o(src), .len_o(len), .rel_o(rel),
    .rel_len_o(rel_len), .fwd_valid_i(fwd_valid), .fwd_ports_i(fwd_ports),
    .fwd_source_i(fwd_source));

  // ------------------------------------------------------------
  // Shared checks
  // ------------------------------------------------------------
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Pops one answer and checks its content and its two-edge latency
  task automatic exp_fwd(input logic [5:0] ports, input logic [2:0] srcx);
    int unsigned t;
    for (int n = 0; n < 8 && rx.rp_q.size() == 0; n++) @(negedge clock);
    if (rx.rp_q.size() == 0 || rx.take_q.size() == 0) chk(48'h1, 48'h0);
    else begin
      t = rx.take_q.pop_front();
      chk(48'(rx.rp_q.pop_front()), 48'(ports));
      chk(48'(rx.rs_q.pop_front()), 48'(srcx));
      // Taken at edge t, staged at t, result launched at edge t+1
      chk(48'(rx.rc_q.pop_front()), 48'(t + 1));
    end
  endtask : exp_fwd

  task automatic look(input logic [47:0] m, input logic [6:0] f, input logic [2:0] s);
    rx.send(m, f, s, 19'h00000, 1'b0, 1'b1);
    rx.idle();
  endtask : look

  task automatic mgmt(input logic tbl, input logic [3:0] sel, input logic [47:0] m,
                      input logic [5:0] p);
    @(negedge clock);
    {m_wr, m_tbl, m_sel, m_mac, m_ports} = {1'b1, tbl, sel, m, p};
    @(negedge clock);
    m_wr = 1'b0;
  endtask : mgmt

  function automatic logic [9:0] ref_idx(input logic [47:0] m, input logic [6:0] f,
                                         input logic [1:0] md);
    logic [15:0] c;
    logic [54:0] k;
    k = {m, f};
    c = 16'h0000;
    for (int i = 54; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ k[i]) ? 16'h1021 : 16'h0000);
    if (md == 2'h1) return c[9:0] + {3'h0, f};
    if (md == 2'h2) return (m[41:32] ^ m[25:16] ^ m[9:0]) + {3'h0, f};
    return m[9:0] + {3'h0, f};
  endfunction : ref_idx

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_hash;
    logic [47:0] ms[3] = '{48'h0123456789AB, 48'hFFFFFFFFFFFF, 48'h0000000003FF};
    logic [6:0] fs[3] = '{7'h00, 7'h7F, 7'h01};
    vlan_en = 1'b1;
    // Request without frame done is ignored, so only the index path is exercised
    for (int md = 0; md < 4; md++) begin
      for (int k = 0; k < 3; k++) begin
        rx.send(ms[k], fs[k], 3'h0, 19'h00000, 1'b0, 1'b0);
        hash_mode = 2'(md);
        #1 chk(48'(DUT.lkp_idx), 48'(ref_idx(ms[k], fs[k], 2'(md))));
      end
    end
    rx.idle();
    vlan_en = 1'b0;
    hash_mode = lookup_pkg::HASH_DEFAULT;
    $display("Test hash done");
  endtask : t_hash

  task automatic t_buffer;
    rx.send(48'h02FF00000009, 7'h00, 3'h0, 19'h3FFFF, 1'b0, 1'b1);
    #1 chk(48'(room), 48'h1);
    rx.send(48'h02FF00000009, 7'h00, 3'h0, 19'h00001, 1'b0, 1'b1);
    #1 chk(48'(room), 48'h1);
    rx.send(48'h02FF00000009, 7'h00, 3'h0, 19'h00001, 1'b0, 1'b1);
    #1 chk(48'(room), 48'h0);
    rx.idle();
    exp_fwd(6'h3E, lookup_pkg::SRC_FLOOD);
    exp_fwd(6'h3E, lookup_pkg::SRC_FLOOD);
    exp_fwd(6'h00, lookup_pkg::SRC_DROP);
    rx.release_buf(19'h40000);
    $display("Test buffer done");
  endtask : t_buffer

  task automatic t_learn;
    rx.send(48'h02AA00000001, 7'h00, 3'h0, 19'h00000, 1'b0, 1'b0);
    rx.idle();
    repeat (4) @(negedge clock);
    chk(48'(rx.rp_q.size()), 48'h0);
    look(48'h02AA00000001, 7'h00, 3'h3);
    exp_fwd(6'h37, lookup_pkg::SRC_FLOOD);
    rx.learn(48'h02AA00000001, 7'h00, 3'h2);
    rx.send(48'h02AA00000001, 7'h00, 3'h0, 19'h00000, 1'b0, 1'b1);
    rx.send(48'h02AA00000001, 7'h00, 3'h0, 19'h00000, 1'b1, 1'b1);
    rx.send(48'h02AA00000001, 7'h00, 3'h2, 19'h00000, 1'b0, 1'b1);
    rx.idle();
    exp_fwd(6'h04, lookup_pkg::SRC_MAIN_DYN);
    exp_fwd(6'h00, lookup_pkg::SRC_DROP);
    exp_fwd(6'h00, lookup_pkg::SRC_MAIN_DYN);
    $display("Test learn done");
  endtask : t_learn

  task automatic t_bucket;
    hash_mode = lookup_pkg::HASH_DIRECT;
    for (int i = 0; i < 4; i++) rx.learn(48'h020000000155 + (48'(i) << 32), 7'h00, 3'(i));
    for (int i = 0; i < 4; i++) begin
      rx.send(48'h020000000155 + (48'(i) << 32), 7'h00, 3'h5, 19'h00000, 1'b0, 1'b1);
    end
    rx.idle();
    for (int i = 0; i < 4; i++) exp_fwd(6'h01 << i, lookup_pkg::SRC_MAIN_DYN);
    hash_mode = lookup_pkg::HASH_DEFAULT;
    $display("Test bucket done");
  endtask : t_bucket

  task automatic t_static;
    mgmt(1'b1, 4'h3, 48'h02AA00000001, 6'h30);
    look(48'h02AA00000001, 7'h00, 3'h0);
    exp_fwd(6'h30, lookup_pkg::SRC_STATIC_TBL);
    mgmt(1'b0, 4'h0, 48'h02EE00000005, 6'h09);
    rx.learn(48'h02EE00000005, 7'h00, 3'h1);
    look(48'h02EE00000005, 7'h00, 3'h0);
    exp_fwd(6'h08, lookup_pkg::SRC_MAIN_STATIC);
    $display("Test static done");
  endtask : t_static

  task automatic t_vlan;
    rx.learn(48'h02CC00000007, 7'h09, 3'h4);
    look(48'h02CC00000007, 7'h03, 3'h0);
    exp_fwd(6'h10, lookup_pkg::SRC_MAIN_DYN);
    vlan_en = 1'b1;
    look(48'h02CC00000007, 7'h03, 3'h0);
    exp_fwd(6'h3E, lookup_pkg::SRC_FLOOD);
    rx.learn(48'h02CC00000007, 7'h03, 3'h1);
    look(48'h02CC00000007, 7'h03, 3'h0);
    exp_fwd(6'h02, lookup_pkg::SRC_MAIN_DYN);
    vlan_en = 1'b0;
    $display("Test vlan done");
  endtask : t_vlan

  task automatic t_rsvd;
    rsvd_en = 1'b1;
    look(48'h0180C2000000, 7'h00, 3'h0);
    exp_fwd(6'h20, lookup_pkg::SRC_RSVD);
    look(48'h0180C2000001, 7'h00, 3'h0);
    exp_fwd(6'h00, lookup_pkg::SRC_RSVD);
    look(48'h0180C2000010, 7'h00, 3'h2);
    exp_fwd(6'h3B, lookup_pkg::SRC_RSVD);
    rsvd_en = 1'b0;
    look(48'h0180C2000000, 7'h00, 3'h0);
    exp_fwd(6'h3E, lookup_pkg::SRC_FLOOD);
    $display("Test reserved done");
  endtask : t_rsvd

  task automatic final_report;
    $display("Checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report

  // Ceiling is far above the expected run of about a hundred cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      final_report();
    end
  end

  initial begin
    repeat (20) @(negedge clock);
    sys_rst = 1'b0;
    t_hash();
    t_buffer();
    t_learn();
    t_bucket();
    t_static();
    t_vlan();
    t_rsvd();
    final_report();
  end
endmodule : tb
`default_nettype wire
